// ==== logic/fcs_params.svh ====
// offsets, field positions, reset values and counts of the flash clock and security block
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
// register byte addresses
`define FCS_OFF_CLK_DIV 12'h000
`define FCS_OFF_OPTIONS 12'h004
`define FCS_OFF_CONFIG 12'h008
`define FCS_OFF_STATUS 12'h00C
`define FCS_OFF_KEY_BASE 12'h020
`define FCS_OFF_KEY_LAST 12'h03C
// flash address of the first key location, for the command port
`define FCS_KEY_FLASH_BASE 16'hFFB0
// clock divider fields
`define FCS_DIV_LOADED_BIT 7
`define FCS_PRESCALE_BIT 6
`define FCS_DIV_MSB 5
// options fields
`define FCS_KEY_EN_BIT 7
`define FCS_REDIR_DIS_BIT 6
`define FCS_OPT_MASK 8'hC3
// configuration fields
`define FCS_CFG_MASK 8'hE0
`define FCS_KEY_ACC_BIT 5
// status fields
`define FCS_ST_SECURE_BIT 0
`define FCS_ST_KEY_OK_BIT 1
`define FCS_ST_OPT_LOADED_BIT 2
// security code that leaves the part open
`define FCS_SEC_OPEN 2'h2
// reset values
`define FCS_RST_BYTE 8'h00
`define FCS_RST_KEY 64'h0000_0000_0000_0000
// bus clock predivide when prescale is set
`define FCS_PRESCALE 8
`define FCS_KEY_BYTES 8
// axi responses
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_SLVERR 2'h2
`endif

// ==== logic/fcs_pkg.sv ====
// types of the flash clock and security block
package fcs_pkg;
	// whole state of the block, registered in one place
	typedef struct packed {
		// axi write side
		logic awready;
		logic wready;
		logic aw_held;
		logic w_held;
		logic [11:0] aw_addr;
		logic aw_unsec;
		logic [7:0] w_byte;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		// axi read side
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// registers
		logic div_loaded;
		logic prescale;
		logic [5:0] divisor;
		logic opt_loaded;
		logic [7:0] options;
		logic [2:0] config_bits;
		// key capture
		logic [63:0] key_buf;
		logic [3:0] key_idx;
		logic key_bad;
		logic key_ok;
		// flash clock
		logic [2:0] pre_cnt;
		logic [5:0] div_cnt;
		logic fclk_tick;
		// pulse timer
		logic timer_busy;
		logic [15:0] timer_left;
		logic timer_done;
		// command port and memory gate
		logic cmd_start;
		logic cmd_refused;
		logic [15:0] cmd_addr;
		logic [7:0] cmd_data;
		logic mem_wen;
		logic [7:0] mem_rdata;
	} fcs_state_s;
endpackage

// ==== logic/fcs_top.sv ====
// flash clock divider, option byte, configuration and backdoor key security logic
`timescale 1ns/1ns
`include "fcs_params.svh"

// Behaviour
// - divisor-loaded flag is read-only, cleared by reset, set by first divider write.
// - divider low seven bits always readable, written only once after reset.
// - program and erase refused until the divisor-loaded flag is set.
// - prescale set feeds the divider with bus clock over PRESCALE (eight by default), else bus clock.
// - divider divides its input by divisor field plus one.
// - timing pulses are one flash clock each; operations count whole pulses.
// - in the first cycle after reset release the nonvolatile option byte is copied into the options register.
// - options bits five to two read zero; writes to options do nothing.
// - with key enable zero, the backdoor key never opens security.
// - eight matching key bytes written in order open security until reset.
// - key byte writes from unsecured sources are not accepted while key-access is set.
// - redirection-disable one turns vector redirection off, zero turns it on.
// - security code 1:0 is open; the other three codes are secure.
// - while secure, unsecured sources cannot reach RAM or flash contents.
// - key match or passing blank check sets security code to 1:0.
// - configuration bits seven to five read/write; four to zero read zero.
// - key-access clear: key location writes start a flash command.
// - key-access set: key location writes are captured as comparison bytes.
// - clearing key-access after eight writes compares; a match opens security.
// - blocked accesses drop write data and read back all zeros.
module fcs_top #(
	parameter int PRESCALE = `FCS_PRESCALE
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// nonvolatile contents from the flash array
	input wire logic [7:0] nonvolatile_option_byte,
	input wire logic [63:0] stored_backdoor_key,
	// command sequencer side
	input wire logic blank_check_pass,
	input wire logic pe_timer_start,
	input wire logic [15:0] pe_timer_pulses,
	output logic pe_enable,
	output logic pe_timer_busy,
	output logic pe_timer_done,
	output logic fclk_tick,
	output logic cmd_start,
	output logic cmd_refused,
	output logic [15:0] cmd_addr,
	output logic [7:0] cmd_data,
	// security state
	output logic secure,
	output logic redirect_enable,
	// memory access gate
	input wire logic mem_wr_req,
	input wire logic mem_unsecured,
	input wire logic [7:0] mem_rdata_in,
	output logic mem_wen,
	output logic [7:0] mem_rdata_out
);

	// prescaler counter is three bits wide
	initial begin
		if (PRESCALE < 1 || PRESCALE > 8) begin
			$error("PRESCALE must lie in 1..8");
		end
	end

	localparam logic [2:0] PRE_LAST = 3'(PRESCALE - 1);

	// open only for the single code 1:0
	function automatic logic is_secure(input logic [7:0] opt);
		is_secure = (opt[1:0] != `FCS_SEC_OPEN);
	endfunction

	// address falls inside the eight key locations
	function automatic logic is_key_addr(input logic [11:0] a);
		is_key_addr = (a >= `FCS_OFF_KEY_BASE) && (a <= `FCS_OFF_KEY_LAST);
	endfunction

	// word index of a key location
	function automatic logic [2:0] key_index(input logic [11:0] a);
		logic [11:0] d;
		d = a - `FCS_OFF_KEY_BASE;
		key_index = d[4:2];
	endfunction

	fcs_pkg::fcs_state_s s;
	fcs_pkg::fcs_state_s next_s;
	logic sec_now;
	logic [2:0] widx;
	logic [11:0] raddr;
	logic div_wrap;

	// next-state logic of the whole block
	always_comb begin
		next_s = s;
		sec_now = is_secure(s.options);
		widx = key_index(s.aw_addr);
		raddr = s_axi_araddr;
		div_wrap = 1'b0;
		next_s.cmd_start = 1'b0;
		next_s.cmd_refused = 1'b0;
		next_s.timer_done = 1'b0;
		next_s.fclk_tick = 1'b0;

		// option byte caught in the first cycle after reset release
		if (!s.opt_loaded) begin
			next_s.options = nonvolatile_option_byte & `FCS_OPT_MASK;
			next_s.opt_loaded = 1'b1;
		end

		// flash clock: optional divide by PRESCALE, then divide by divisor plus one
		if (s.div_loaded) begin
			if (!s.prescale || s.pre_cnt == PRE_LAST) begin
				next_s.pre_cnt = 3'h0;
				div_wrap = 1'b1;
			end else begin
				next_s.pre_cnt = s.pre_cnt + 3'h1;
			end
			if (div_wrap) begin
				if (s.div_cnt >= s.divisor) begin
					next_s.div_cnt = 6'h00;
					next_s.fclk_tick = 1'b1;
				end else begin
					next_s.div_cnt = s.div_cnt + 6'h01;
				end
			end
		end

		// pulse timer counts whole flash clock periods
		if (s.timer_busy && s.fclk_tick) begin
			if (s.timer_left <= 16'h0001) begin
				next_s.timer_busy = 1'b0;
				next_s.timer_left = 16'h0000;
				next_s.timer_done = 1'b1;
			end else begin
				next_s.timer_left = s.timer_left - 16'h0001;
			end
		end
		if (pe_timer_start && !s.timer_busy) begin
			if (s.div_loaded && pe_timer_pulses != 16'h0000) begin
				next_s.timer_busy = 1'b1;
				next_s.timer_left = pe_timer_pulses;
			end else begin
				next_s.cmd_refused = 1'b1;
			end
		end

		// blank check of a fully erased array opens the part
		if (blank_check_pass) begin
			next_s.options[1:0] = `FCS_SEC_OPEN;
		end

		// memory gate blocks unsecured sources while secure
		next_s.mem_wen = mem_wr_req && !(sec_now && mem_unsecured);
		next_s.mem_rdata = (sec_now && mem_unsecured) ? 8'h00 : mem_rdata_in;

		// write address and data channels, taken in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.awready = 1'b0;
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
			next_s.aw_unsec = s_axi_awprot[1];
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.wready = 1'b0;
			next_s.w_held = 1'b1;
			next_s.w_byte = s_axi_wdata[7:0];
			next_s.w_lane = s_axi_wstrb[0];
		end

		// register write once both halves are held
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `FCS_RESP_OKAY;
			if (s.aw_addr == `FCS_OFF_CLK_DIV) begin
				if (!s.div_loaded) begin
					next_s.div_loaded = 1'b1;
					if (s.w_lane) begin
						next_s.prescale = s.w_byte[`FCS_PRESCALE_BIT];
						next_s.divisor = s.w_byte[`FCS_DIV_MSB:0];
					end
					next_s.pre_cnt = 3'h0;
					next_s.div_cnt = 6'h00;
				end
			end else if (s.aw_addr == `FCS_OFF_OPTIONS) begin
				next_s.bresp = `FCS_RESP_OKAY;
			end else if (s.aw_addr == `FCS_OFF_CONFIG) begin
				if (s.w_lane) begin
					next_s.config_bits = s.w_byte[7:5];
					// falling key access ends a key entry and compares
					if (s.config_bits[0] && !s.w_byte[`FCS_KEY_ACC_BIT]) begin
						if (s.options[`FCS_KEY_EN_BIT] && !s.key_bad
							&& s.key_idx == 4'(`FCS_KEY_BYTES)
							&& s.key_buf == stored_backdoor_key) begin
							next_s.options[1:0] = `FCS_SEC_OPEN;
							next_s.key_ok = 1'b1;
						end
						next_s.key_idx = 4'h0;
						next_s.key_bad = 1'b0;
					end
					// rising key access starts a fresh entry
					if (!s.config_bits[0] && s.w_byte[`FCS_KEY_ACC_BIT]) begin
						next_s.key_idx = 4'h0;
						next_s.key_bad = 1'b0;
					end
				end
			end else if (s.aw_addr == `FCS_OFF_STATUS) begin
				next_s.bresp = `FCS_RESP_OKAY;
			end else if (is_key_addr(s.aw_addr) && s.aw_addr[1:0] == 2'h0) begin
				if (s.config_bits[0]) begin
					if (s.aw_unsec) begin
						next_s.key_bad = 1'b1;
					end else if (s.w_lane) begin
						if ({1'b0, widx} != s.key_idx) begin
							next_s.key_bad = 1'b1;
						end else begin
							next_s.key_buf[8 * (7 - widx) +: 8] = s.w_byte;
							next_s.key_idx = s.key_idx + 4'h1;
						end
					end
				end else if (s.w_lane) begin
					next_s.cmd_addr = `FCS_KEY_FLASH_BASE + {13'h0000, widx};
					next_s.cmd_data = s.w_byte;
					if (s.div_loaded) begin
						next_s.cmd_start = 1'b1;
					end else begin
						next_s.cmd_refused = 1'b1;
					end
				end
			end else begin
				next_s.bresp = `FCS_RESP_SLVERR;
			end
		end

		// write response handshake frees both channels
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end

		// read channel: one read at a time
		if (s_axi_arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = `FCS_RESP_OKAY;
			next_s.rdata = 32'h0000_0000;
			if (raddr == `FCS_OFF_CLK_DIV) begin
				next_s.rdata[7:0] = {s.div_loaded, s.prescale, s.divisor};
			end else if (raddr == `FCS_OFF_OPTIONS) begin
				next_s.rdata[7:0] = s.options & `FCS_OPT_MASK;
			end else if (raddr == `FCS_OFF_CONFIG) begin
				next_s.rdata[7:0] = {s.config_bits, 5'h00};
			end else if (raddr == `FCS_OFF_STATUS) begin
				next_s.rdata[`FCS_ST_SECURE_BIT] = sec_now;
				next_s.rdata[`FCS_ST_KEY_OK_BIT] = s.key_ok;
				next_s.rdata[`FCS_ST_OPT_LOADED_BIT] = s.opt_loaded;
			end else if (is_key_addr(raddr) && raddr[1:0] == 2'h0) begin
				next_s.rdata = 32'h0000_0000;
			end else begin
				next_s.rresp = `FCS_RESP_SLVERR;
			end
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.options <= `FCS_RST_BYTE;
			s.key_buf <= `FCS_RST_KEY;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops, except secure and redirect_enable, which are decoded from options
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign pe_enable = s.div_loaded;
	assign pe_timer_busy = s.timer_busy;
	assign pe_timer_done = s.timer_done;
	assign fclk_tick = s.fclk_tick;
	assign cmd_start = s.cmd_start;
	assign cmd_refused = s.cmd_refused;
	assign cmd_addr = s.cmd_addr;
	assign cmd_data = s.cmd_data;
	// secure until the option byte arrives, since reset code 0:0 is secure
	assign secure = is_secure(s.options);
	assign redirect_enable = s.opt_loaded && !s.options[`FCS_REDIR_DIS_BIT];
	assign mem_wen = s.mem_wen;
	assign mem_rdata_out = s.mem_rdata;

endmodule

// ==== test/fcs_top_asserts.sv ====
// concurrent checks on the ports of the flash clock and security block
`timescale 1ns/1ns
module fcs_top_asserts #(
	parameter int PRESCALE = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// sequencer side
	input wire logic pe_enable,
	input wire logic cmd_start,
	input wire logic fclk_tick,
	input wire logic pe_timer_start,
	input wire logic [15:0] pe_timer_pulses,
	input wire logic pe_timer_busy,
	input wire logic pe_timer_done,
	// security and memory gate
	input wire logic secure,
	input wire logic mem_wr_req,
	input wire logic mem_unsecured,
	input wire logic [7:0] mem_rdata_in,
	input wire logic mem_wen,
	input wire logic [7:0] mem_rdata_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// both write halves taken together, and an accepted timer start
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_tmr_go;
		pe_timer_start && pe_enable && !pe_timer_busy && pe_timer_pulses != 16'h0000;
	endsequence
	wr_resp_time_a: assert property (s_wr_take |=> ##1 s_axi_bvalid)
		else $error("write response late");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	cmd_gate_a: assert property (cmd_start |-> pe_enable)
		else $error("command before divider load");
	loaded_keep_a: assert property (pe_enable |=> pe_enable)
		else $error("divider load flag lost");
	fclk_gate_a: assert property (fclk_tick |-> pe_enable)
		else $error("flash clock without divider");
	tmr_start_a: assert property (s_tmr_go |=> pe_timer_busy)
		else $error("timer start ignored");
	tmr_done_a: assert property (pe_timer_done |-> $past(pe_timer_busy))
		else $error("timer done while idle");
	sec_no_rise_a: assert property (!$rose(secure))
		else $error("security reengaged");
	mem_wen_a: assert property (##1 mem_wen == $past(mem_wr_req && !(secure && mem_unsecured)))
		else $error("memory write gate wrong");
	rd_block_a: assert property (secure && mem_unsecured |=> mem_rdata_out == 8'h00)
		else $error("blocked read not zero");
	rd_pass_a: assert property (!(secure && mem_unsecured) |=> mem_rdata_out == $past(mem_rdata_in))
		else $error("read data not passed");
endmodule

bind fcs_top fcs_top_asserts #(.PRESCALE(PRESCALE)) i_chk(.*);

// ==== test/flash_clock_security_config_bench.sv ====
// self-checking bench of the flash clock and security block
`timescale 1ns/1ns
`include "fcs_params.svh"
module flash_clock_security_config_bench;
	localparam int PS = 4;
	logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, br;
	logic [7:0] nonvolatile_option_byte, cmd_data, mem_rdata_in, mem_rdata_out, ob, dv;
	logic [63:0] stored_backdoor_key;
	logic blank_check_pass, pe_timer_start, pe_enable, pe_timer_busy, pe_timer_done, fclk_tick;
	logic cmd_start, cmd_refused, secure, redirect_enable, mem_wr_req, mem_unsecured, mem_wen;
	logic [15:0] pe_timer_pulses, cmd_addr;
	logic m_open;
	int mismatches, num_checks, n_st, n_ref, t;
	fcs_top #(.PRESCALE(PS)) i_dut(.*);
	// bus clock
	always #4 clk_sys = ~clk_sys;
	// command port pulse counters
	always @(posedge clk_sys) begin
		n_st <= n_st + cmd_start;
		n_ref <= n_ref + cmd_refused;
	end
	task test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one axi write, response code kept in br
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [2:0] p);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awprot <= p;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		br = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// one axi read compared with a byte and a response
	task rc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		chk({s_axi_rresp, s_axi_rdata}, {r, 24'h00_0000, e});
		s_axi_rready <= 1'h0;
	endtask
	// reset with a new option byte in the array
	task rs(input logic [7:0] o);
		rst_n <= 1'h0;
		nonvolatile_option_byte <= o;
		m_open = (o[1:0] == `FCS_SEC_OPEN);
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk_sys);
	endtask
	// full backdoor key entry, then security compared with the model
	task key(input logic [63:0] k, input logic [2:0] p);
		wr(`FCS_OFF_CONFIG, 8'h20, 3'h0);
		for (int i = 0; i < `FCS_KEY_BYTES; i++) begin
			wr(`FCS_OFF_KEY_BASE + 12'(4 * i), k[63 - 8 * i -: 8], p);
		end
		wr(`FCS_OFF_CONFIG, 8'h00, 3'h0);
		if (nonvolatile_option_byte[7] && !p[1] && k == stored_backdoor_key) m_open = 1'h1;
		repeat (2) @(posedge clk_sys);
		chk(secure, !m_open);
	endtask
	// one unsecured memory write and read through the gate
	task mg();
		@(posedge clk_sys);
		mem_wr_req <= 1'h1;
		mem_rdata_in <= 8'($urandom);
		@(posedge clk_sys);
		mem_wr_req <= 1'h0;
		@(posedge clk_sys);
		chk({mem_wen, mem_rdata_out}, {m_open, m_open ? mem_rdata_in : 8'h00});
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		test_done();
	end
	// main sequence
	initial begin
		{clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
		{s_axi_arvalid, s_axi_rready, blank_check_pass, pe_timer_start, mem_wr_req} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0000_0000;
		{s_axi_wdata, pe_timer_pulses, mem_rdata_in, nonvolatile_option_byte} = 64'h0;
		{s_axi_wstrb, mem_unsecured, n_st, n_ref} = {4'hF, 1'h1, 64'h0};
		void'($urandom(94));
		stored_backdoor_key = {$urandom, $urandom};
		for (int c = 0; c < 4; c++) begin
			ob = {c[0], c[1], 4'($urandom), 2'(c)};
			rs(ob);
			chk({secure, redirect_enable}, {!m_open, !ob[6]});
			wr(`FCS_OFF_OPTIONS, ~ob, 3'h0);
			rc(`FCS_OFF_OPTIONS, ob & `FCS_OPT_MASK, `FCS_RESP_OKAY);
		end
		chk(pe_enable, 1'h0);
		wr(`FCS_OFF_KEY_BASE, 8'h5A, 3'h0);
		rc(`FCS_OFF_CLK_DIV, 8'h00, `FCS_RESP_OKAY);
		wr(`FCS_OFF_CONFIG, 8'hFF, 3'h0);
		rc(`FCS_OFF_CONFIG, 8'hE0, `FCS_RESP_OKAY);
		wr(`FCS_OFF_CONFIG, 8'h00, 3'h0);
		dv = {1'h0, 1'($urandom), 6'($urandom % 4 + 1)}; // scaled down for run time
		wr(`FCS_OFF_CLK_DIV, dv, 3'h0);
		wr(`FCS_OFF_CLK_DIV, ~dv, 3'h0);
		rc(`FCS_OFF_CLK_DIV, dv | 8'h80, `FCS_RESP_OKAY);
		// flash clock period
		do @(posedge clk_sys); while (fclk_tick !== 1'h1);
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
		end while (fclk_tick !== 1'h1);
		chk(t, (dv[6] ? PS : 1) * (dv[5:0] + 1));
		// timer of three pulses
		pe_timer_pulses <= 16'h0003;
		pe_timer_start <= 1'h1;
		@(posedge clk_sys);
		pe_timer_start <= 1'h0;
		t = 0;
		do begin
			@(posedge clk_sys);
			t += fclk_tick;
		end while (pe_timer_done !== 1'h1);
		chk(t, 3);
		wr(`FCS_OFF_KEY_BASE + 12'h008, 8'hC3, 3'h0);
		@(posedge clk_sys);
		chk({n_ref[1:0], n_st[1:0], cmd_addr, cmd_data}, {4'h5, `FCS_KEY_FLASH_BASE + 16'h0002, 8'hC3});
		mg();
		key(stored_backdoor_key ^ 64'h1, 3'h0);
		key(stored_backdoor_key, 3'h2);
		key(stored_backdoor_key, 3'h0);
		rc(`FCS_OFF_STATUS, {5'h00, 1'h1, m_open, !m_open}, `FCS_RESP_OKAY);
		mg();
		rs(8'h03);
		key(stored_backdoor_key, 3'h0);
		blank_check_pass <= 1'h1;
		@(posedge clk_sys);
		blank_check_pass <= 1'h0;
		m_open = 1'h1;
		repeat (2) @(posedge clk_sys);
		chk(secure, !m_open);
		wr(12'h100, 8'h11, 3'h0);
		chk(br, `FCS_RESP_SLVERR);
		rc(12'h100, 8'h00, `FCS_RESP_SLVERR);
		test_done();
	end
endmodule
